// ===== ptc_pin_model.sv
// Far-side model of the external clock pin and the capture pin
`timescale 1ns/100ps
module ptc_pin_model (
	input  wire logic sys_clk,
	input  wire logic clkRun,
	input  wire logic capLevel,
	output logic      extClockPin,
	output logic      captureInputPin
);
	logic [1:0] phaseCnt;

	// ****************************************
	// Pin clock: 8 cycles a period, still at 0 when off
	// ****************************************
	initial begin
		phaseCnt = 2'h0;
		extClockPin = 1'b0;
	end
	always @(posedge sys_clk) begin
		if (!clkRun) begin
			phaseCnt <= 2'h0;
			extClockPin <= 1'b0;
		end else begin
			phaseCnt <= phaseCnt + 2'h1;
			if (phaseCnt == 2'h3) begin
				extClockPin <= ~extClockPin;
			end
		end
	end
	assign captureInputPin = capLevel;
endmodule

// ===== ptc_pin_sync.sv
// Three-stage synchroniser with edge pulses for one pin
`timescale 1ns/100ps
module ptc_pin_sync (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic pinIn,
	output logic      pinLevel,
	output logic      pinRise,
	output logic      pinFall
);
	logic [2:0] syncReg;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			syncReg <= 3'h0;
		end else begin
			syncReg <= {syncReg[1:0], pinIn};
		end
	end

	// A change is flagged while stages two and three differ
	assign pinLevel = syncReg[2];
	assign pinRise  = syncReg[1] & ~syncReg[2];
	assign pinFall  = ~syncReg[1] & syncReg[2];
endmodule

// ===== ptc_pkg.sv
// Register map, field layout and timing constants of the periodic timer core
package ptc_pkg;

	// ****************************************
	// Register indices on the byte port
	// ****************************************
	localparam int            ADDR_W        = 3;
	localparam int            DATA_W        = 8;
	localparam int            CNT_W         = 10;
	localparam logic [2:0]    ADDR_CTRL_A   = 3'h0;
	localparam logic [2:0]    ADDR_CTRL_B   = 3'h1;
	localparam logic [2:0]    ADDR_CNT_LO   = 3'h2;
	localparam logic [2:0]    ADDR_CNT_HI   = 3'h3;
	localparam logic [2:0]    ADDR_CMPA_LO  = 3'h4;
	localparam logic [2:0]    ADDR_CMPA_HI  = 3'h5;
	localparam logic [2:0]    ADDR_PER_LO   = 3'h6;
	localparam logic [2:0]    ADDR_PER_HI   = 3'h7;
	localparam logic [7:0]    CTRL_A_RESET  = 8'h00;
	localparam logic [7:0]    CTRL_B_RESET  = 8'h00;
	localparam logic [7:0]    CTRL_A_MASK   = 8'hF8;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int            POS_PAUSE     = 7;
	localparam int            POS_CKSEL     = 4;
	localparam int            POS_RUN       = 3;
	localparam int            POS_MODE      = 6;
	localparam int            POS_PINFN     = 4;
	localparam int            POS_OC        = 3;
	localparam int            POS_POL       = 2;
	localparam int            POS_CAPSRC    = 1;
	localparam int            POS_CLRSEL    = 0;

	// ****************************************
	// Field encodings
	// ****************************************
	localparam logic [1:0]    MODE_CMP      = 2'h0;
	localparam logic [1:0]    MODE_CAP      = 2'h1;
	localparam logic [1:0]    MODE_PWM      = 2'h2;
	localparam logic [1:0]    MODE_TC       = 2'h3;
	localparam logic [1:0]    FN_0          = 2'h0;
	localparam logic [1:0]    FN_1          = 2'h1;
	localparam logic [1:0]    FN_2          = 2'h2;
	localparam logic [1:0]    FN_3          = 2'h3;

	// ****************************************
	// Clock rates and divider counts
	// ****************************************
	localparam longint        SYS_CLK_HZ    = 200000000;
	localparam longint        SUB_CLK_HZ    = 32768;
	localparam int            SUB_DIV_DEF   = int'(SYS_CLK_HZ / SUB_CLK_HZ);
	localparam int            DIV_SYS4      = 4;
	localparam int            DIV_HIGH16    = 16;
	localparam int            DIV_HIGH64    = 64;

	typedef enum logic {PULSE_IDLE, PULSE_ACTIVE} ptc_pulse_t;

endpackage

// ===== ptc_tick_gen.sv
// Divided counting enables derived from the system clock
`timescale 1ns/100ps
module ptc_tick_gen #(
	parameter int SUB_DIV = ptc_pkg::SUB_DIV_DEF
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	output logic      tickSys4,
	output logic      tickHigh16,
	output logic      tickHigh64,
	output logic      tickSub
);
	import ptc_pkg::*;

	if (SUB_DIV < 2) begin : g_badSubDiv
		$error("SUB_DIV must be at least 2");
	end

	logic [5:0]  preReg;
	logic [31:0] subReg;
	wire         subWrap = (subReg == 32'(SUB_DIV - 1));

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			preReg <= 6'h00;
			subReg <= 32'h0;
		end else begin
			preReg <= preReg + 6'h01;
			subReg <= subWrap ? 32'h0 : subReg + 32'h1;
		end
	end

	// High clock is taken equal to the system clock
	assign tickSys4   = (preReg[1:0] == 2'(DIV_SYS4 - 1));
	assign tickHigh16 = (preReg[3:0] == 4'(DIV_HIGH16 - 1));
	assign tickHigh64 = (preReg == 6'(DIV_HIGH64 - 1));
	assign tickSub    = subWrap;
endmodule

// ===== ptc_timer.sv
// Ten-bit periodic timer core with byte register port and waveform pins
// Behaviour
// - Ten-bit counter counts up on each active tick of the selected source.
// - Comparators A and period compare the counter against stored values.
// - Counter cannot be loaded; it clears when run goes 0 to 1.
// - Counter clears on overflow or, except in capture mode, on selected compare match; match raises request.
// - Pause bit freezes the counter; clearing it resumes from held value.
// - Clock select: sys/4, sys, high/16, high/64, sub, sub, pin rise, fall.
// - Clearing run stops counting, keeps the value; setting it restarts at zero.
// - Run rising edge returns the output to its initial level in output modes.
// - Mode field: compare output, capture, PWM or single pulse, timer/counter.
// - Compare mode A match: unchanged, low, high or toggle by pin function.
// - Requested level equal to the initial level leaves the pin unchanged.
// - PWM mode pin function: inactive, active, PWM, single pulse.
// - Capture mode edge: rising, falling, both, disabled.
// - Counter pair is read only; compare A and period pairs read and write.
// - Low three bits of control register A read zero.
// - Output control bit sets initial level or active level.
// - Polarity bit inverts the true output pin except in timer/counter mode.
// - Low byte write goes to a buffer, moved on high byte write.
// - High byte read copies the low byte into a buffer for later read.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module ptc_timer #(
	parameter int SUB_DIV = ptc_pkg::SUB_DIV_DEF
) (
	input  wire logic                        sys_clk,
	input  wire logic                        rst_n,
	input  wire logic [ptc_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic [ptc_pkg::DATA_W-1:0]  regWrData,
	input  wire logic                        regWrStb,
	input  wire logic                        regRdStb,
	output logic      [ptc_pkg::DATA_W-1:0]  regRdData,
	input  wire logic                        extClockPin,
	input  wire logic                        captureInputPin,
	output logic                             timerOutputPin,
	output logic                             invertedOutputPin,
	output logic                             irqCompareA,
	output logic                             irqPeriod
);
	import ptc_pkg::*;

	// ****************************************
	// Registers and field decode
	// ****************************************
	logic [7:0]       ctrlAReg;
	logic [7:0]       ctrlBReg;
	logic [CNT_W-1:0] cntReg;
	logic [CNT_W-1:0] cntNext;
	logic [CNT_W-1:0] cmpAReg;
	logic [CNT_W-1:0] perReg;
	logic [7:0]       wrBufReg;
	logic [7:0]       rdBufReg;
	logic [7:0]       rdNext;
	logic             runPrevReg;
	logic             outLevelReg;
	logic             outLevelNext;
	logic             irqAReg;
	logic             irqPReg;
	logic             timerPinReg;
	logic             invPinReg;
	logic             countTick;
	ptc_pulse_t       pulseReg;
	ptc_pulse_t       pulseNext;

	wire       pauseBit  = ctrlAReg[POS_PAUSE];
	wire [2:0] clkSel    = ctrlAReg[POS_CKSEL +: 3];
	wire       runBit    = ctrlAReg[POS_RUN];
	wire [1:0] mode      = ctrlBReg[POS_MODE +: 2];
	wire [1:0] pinFn     = ctrlBReg[POS_PINFN +: 2];
	wire       outCtrl   = ctrlBReg[POS_OC];
	wire       polBit    = ctrlBReg[POS_POL];
	wire       capSrc    = ctrlBReg[POS_CAPSRC];
	wire       clrSel    = ctrlBReg[POS_CLRSEL];

	wire       wrCtrlA   = regWrStb && (regAddr == ADDR_CTRL_A);
	wire       wrCtrlB   = regWrStb && (regAddr == ADDR_CTRL_B);
	wire       wrLowByte = regWrStb && (regAddr == ADDR_CMPA_LO || regAddr == ADDR_PER_LO);
	wire       wrCmpAHi  = regWrStb && (regAddr == ADDR_CMPA_HI);
	wire       wrPerHi   = regWrStb && (regAddr == ADDR_PER_HI);
	wire       rdCntHi   = regRdStb && (regAddr == ADDR_CNT_HI);
	wire       rdCmpAHi  = regRdStb && (regAddr == ADDR_CMPA_HI);
	wire       rdPerHi   = regRdStb && (regAddr == ADDR_PER_HI);

	// ****************************************
	// Pin synchronisers and clock enables
	// ****************************************
	logic extRise;
	logic extFall;
	logic capRise;
	logic capFall;
	logic tickSys4;
	logic tickHigh16;
	logic tickHigh64;
	logic tickSub;

	ptc_pin_sync u_extSync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.pinIn    (extClockPin),
		.pinLevel (),
		.pinRise  (extRise),
		.pinFall  (extFall)
	);

	ptc_pin_sync u_capSync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.pinIn    (captureInputPin),
		.pinLevel (),
		.pinRise  (capRise),
		.pinFall  (capFall)
	);

	ptc_tick_gen #(
		.SUB_DIV (SUB_DIV)
	) u_ticks (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.tickSys4   (tickSys4),
		.tickHigh16 (tickHigh16),
		.tickHigh64 (tickHigh64),
		.tickSub    (tickSub)
	);

	wire [7:0] tickSrc = {extFall, extRise, tickSub, tickSub,
	                      tickHigh64, tickHigh16, 1'b1, tickSys4};
	assign countTick = tickSrc[clkSel];

	// ****************************************
	// Counter and comparators
	// ****************************************
	wire counting = runBit && !pauseBit;
	wire runRise  = runBit && !runPrevReg;
	wire step     = counting && countTick && !runRise;
	wire matchA   = step && (cntReg == cmpAReg);
	wire matchP   = step && (cntReg == perReg);
	wire clearHit = clrSel ? matchA : matchP;

	assign cntNext = runRise ? {CNT_W{1'b0}} :
	                 !step   ? cntReg :
	                 (clearHit && mode != MODE_CAP) ? {CNT_W{1'b0}} :
	                 cntReg + 10'h001;

	wire srcRise  = capSrc ? extRise : capRise;
	wire srcFall  = capSrc ? extFall : capFall;
	wire capEdge  = (pinFn == FN_0) ? srcRise :
	                (pinFn == FN_1) ? srcFall :
	                (pinFn == FN_2) ? (srcRise || srcFall) : 1'b0;
	wire capHit   = (mode == MODE_CAP) && runBit && capEdge;

	// ****************************************
	// Output waveform
	// ****************************************
	wire outMode  = (mode == MODE_CMP) || (mode == MODE_PWM);
	wire pwmLevel = (cntReg < cmpAReg) ? outCtrl : !outCtrl;

	// Single pulse starts on the trigger pin or run edge, ends on match A
	always_comb begin
		pulseNext = pulseReg;
		case (pulseReg)
			PULSE_IDLE: begin
				if (mode == MODE_PWM && pinFn == FN_3 && runBit && (extRise || runRise)) begin
					pulseNext = PULSE_ACTIVE;
				end
			end
			default: begin
				if (!runBit || matchA || mode != MODE_PWM) begin
					pulseNext = PULSE_IDLE;
				end
			end
		endcase
	end

	always_comb begin
		outLevelNext = outLevelReg;
		if (runRise && outMode) begin
			outLevelNext = outCtrl;
		end else if (mode == MODE_CMP && matchA) begin
			case (pinFn)
				FN_1:    outLevelNext = 1'b0;
				FN_2:    outLevelNext = 1'b1;
				FN_3:    outLevelNext = !outLevelReg;
				default: outLevelNext = outLevelReg;
			endcase
		// forced, PWM and single pulse levels
		end else if (mode == MODE_PWM) begin
			case (pinFn)
				FN_0:    outLevelNext = !outCtrl;
				FN_1:    outLevelNext = outCtrl;
				FN_2:    outLevelNext = pwmLevel;
				default: outLevelNext = (pulseNext == PULSE_ACTIVE) ? outCtrl : !outCtrl;
			endcase
		end
	end

	// polarity, held low in timer/counter mode
	wire timerPinNext = (mode == MODE_TC) ? 1'b0 : (outLevelReg ^ polBit);

	// ****************************************
	// Read data decode
	// ****************************************
	// read paths
	always_comb begin
		if (regAddr == ADDR_CTRL_A) begin
			rdNext = ctrlAReg & CTRL_A_MASK;
		end else if (regAddr == ADDR_CTRL_B) begin
			rdNext = ctrlBReg;
		end else if (regAddr == ADDR_CNT_HI) begin
			rdNext = {6'h00, cntReg[9:8]};
		end else if (regAddr == ADDR_CMPA_HI) begin
			rdNext = {6'h00, cmpAReg[9:8]};
		end else if (regAddr == ADDR_PER_HI) begin
			rdNext = {6'h00, perReg[9:8]};
		end else begin
			rdNext = rdBufReg;
		end
	end

	// ****************************************
	// Clocked state
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrlAReg <= CTRL_A_RESET;
			ctrlBReg <= CTRL_B_RESET;
		end else begin
			if (wrCtrlA) begin
				ctrlAReg <= regWrData & CTRL_A_MASK;
			end
			if (wrCtrlB) begin
				ctrlBReg <= regWrData;
			end
		end
	end

	// low byte buffered until high byte write
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wrBufReg <= 8'h00;
			cmpAReg  <= 10'h000;
			perReg   <= 10'h000;
		end else begin
			if (wrLowByte) begin
				wrBufReg <= regWrData;
			end
			if (capHit) begin
				cmpAReg <= cntReg;
			end else if (wrCmpAHi) begin
				cmpAReg <= {regWrData[1:0], wrBufReg};
			end
			if (wrPerHi) begin
				perReg <= {regWrData[1:0], wrBufReg};
			end
		end
	end

	// high byte read latches the low byte
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdBufReg  <= 8'h00;
			regRdData <= 8'h00;
		end else begin
			if (rdCntHi) begin
				rdBufReg <= cntReg[7:0];
			end else if (rdCmpAHi) begin
				rdBufReg <= cmpAReg[7:0];
			end else if (rdPerHi) begin
				rdBufReg <= perReg[7:0];
			end
			regRdData <= regRdStb ? rdNext : 8'h00;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cntReg      <= 10'h000;
			runPrevReg  <= 1'b0;
			outLevelReg <= 1'b0;
			pulseReg    <= PULSE_IDLE;
			irqAReg     <= 1'b0;
			irqPReg     <= 1'b0;
			timerPinReg <= 1'b0;
			invPinReg   <= 1'b1;
		end else begin
			cntReg      <= cntNext;
			runPrevReg  <= runBit;
			outLevelReg <= outLevelNext;
			pulseReg    <= pulseNext;
			irqAReg     <= (mode == MODE_CAP) ? capHit : matchA;
			irqPReg     <= matchP;
			timerPinReg <= timerPinNext;
			invPinReg   <= !timerPinNext;
		end
	end

	assign timerOutputPin    = timerPinReg;
	assign invertedOutputPin = invPinReg;
	assign irqCompareA       = irqAReg;
	assign irqPeriod         = irqPReg;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_runRise;
		!runBit ##1 runBit;
	endsequence
	property p_clear_on_run;
		s_runRise |=> cntReg == 10'h000;
	endproperty
	a_clear_on_run: assert property (p_clear_on_run) else $error("run edge did not clear");
	property p_count_up;
		step && !clearHit && mode != MODE_CAP |=> cntReg == $past(cntReg) + 10'h001;
	endproperty
	a_count_up: assert property (p_count_up) else $error("counter did not step");
	property p_overflow;
		step && cntReg == 10'h3FF |=> cntReg == 10'h000;
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow did not clear");
	property p_pause_hold;
		runBit && pauseBit && runPrevReg |=> $stable(cntReg);
	endproperty
	a_pause_hold: assert property (p_pause_hold) else $error("paused counter moved");
	property p_stop_hold;
		!runBit [*2] |-> $stable(cntReg);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");
	property p_init_level;
		s_runRise ##0 (mode == MODE_CMP) |=> outLevelReg == $past(outCtrl);
	endproperty
	a_init_level: assert property (p_init_level) else $error("initial level not set");
	property p_irq_a;
		step && cntReg == cmpAReg && mode != MODE_CAP |=> irqCompareA ##1 !irqCompareA;
	endproperty
	a_irq_a: assert property (p_irq_a) else $error("compare A request wrong");
	property p_inverted;
		invertedOutputPin == !timerOutputPin;
	endproperty
	a_inverted: assert property (p_inverted) else $error("inverted pin mismatch");
	property p_polarity;
		mode != MODE_TC |=> timerOutputPin == ($past(outLevelReg) ^ $past(polBit));
	endproperty
	a_polarity: assert property (p_polarity) else $error("polarity wrong");
	property p_ctrl_a_low;
		regRdStb && regAddr == ADDR_CTRL_A |=> regRdData[2:0] == 3'h0;
	endproperty
	a_ctrl_a_low: assert property (p_ctrl_a_low) else $error("reserved bits set");
	property p_pair_write;
		wrLowByte && regAddr == ADDR_PER_LO ##1 wrPerHi && !wrLowByte
			|=> perReg[7:0] == $past(regWrData, 2);
	endproperty
	a_pair_write: assert property (p_pair_write) else $error("low byte not moved");
endmodule

// ===== tb_ptc_timer.sv
// Self-checking bench of the periodic timer core
`timescale 1ns/100ps
module tb_ptc_timer;
	import ptc_pkg::*;
	logic       sys_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [2:0] regAddr = 3'h0;
	logic [7:0] regWrData = 8'h00;
	logic       regWrStb = 1'b0;
	logic       regRdStb = 1'b0;
	logic [7:0] regRdData;
	logic       extClockPin, captureInputPin, timerOutputPin, invertedOutputPin;
	logic       irqCompareA, irqPeriod;
	logic       clkRun = 1'b0;
	logic       capLevel = 1'b0;
	int         nFail = 0;
	int         compares = 0;
	logic [9:0] v, w;
	int         n, k;
	int         divTab [8] = '{4, 1, 16, 64, 4, 4, 8, 8};

	always #2.5 sys_clk = ~sys_clk;

	ptc_timer #(.SUB_DIV(4)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
		.extClockPin(extClockPin), .captureInputPin(captureInputPin),
		.timerOutputPin(timerOutputPin), .invertedOutputPin(invertedOutputPin),
		.irqCompareA(irqCompareA), .irqPeriod(irqPeriod));
	ptc_pin_model u_pins (.sys_clk(sys_clk), .clkRun(clkRun), .capLevel(capLevel),
		.extClockPin(extClockPin), .captureInputPin(captureInputPin));

	// ****************************************
	// Bus access and checking
	// ****************************************
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge sys_clk);
		regWrStb <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge sys_clk);
		regRdStb <= 1'b0;
		#1;
		d = regRdData;
	endtask
	task automatic rd16(input logic [2:0] hiAddr, output logic [9:0] r);
		logic [7:0] hi, lo;
		rd(hiAddr, hi);
		rd(hiAddr - 3'h1, lo);
		r = {hi[1:0], lo};
	endtask
	// Low then high byte on back-to-back strobes
	task automatic wr16(input logic [2:0] hiAddr, input logic [9:0] d);
		@(posedge sys_clk);
		regAddr <= hiAddr - 3'h1;
		regWrData <= d[7:0];
		regWrStb <= 1'b1;
		@(posedge sys_clk);
		regAddr <= hiAddr;
		regWrData <= {6'h00, d[9:8]};
		@(posedge sys_clk);
		regWrStb <= 1'b0;
	endtask
	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		compares++;
		if (got !== exp) begin
			nFail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chkPins(input logic exp);
		chk("timerOutputPin", {9'h0, exp}, {9'h0, timerOutputPin});
		chk("invertedOutputPin", {9'h0, ~exp}, {9'h0, invertedOutputPin});
	endtask
	// Cycles from the call to the next pulse of the chosen request
	task automatic waitIrq(input logic usePer, output int c);
		c = 0;
		do begin
			@(posedge sys_clk);
			#1;
			c++;
		end while (((usePer ? irqPeriod : irqCompareA) !== 1'b1) && c < 3000);
		if (c >= 3000) begin
			nFail++;
			$display("MISMATCH irq wait expected pulse seen none");
		end
	endtask
	// Cycles in which the true pin or the A request is seen high
	task automatic cntOnes(input int len, input logic usePin, output int c);
		c = 0;
		repeat (len) begin
			@(posedge sys_clk);
			#1;
			if ((usePin ? timerOutputPin : irqCompareA) === 1'b1) c++;
		end
	endtask
	// Stop first, then set mode, then start again
	task automatic setup(input logic [7:0] ctrlB, input logic [7:0] ctrlA);
		wr(ADDR_CTRL_A, 8'h00);
		wr(ADDR_CTRL_B, ctrlB);
		wr(ADDR_CTRL_A, ctrlA);
	endtask
	task automatic endOfTest;
		$display("Checks %0d mismatches %0d", compares, nFail);
		if (nFail == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#200000;
		nFail++;
		endOfTest;
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(ADDR_CTRL_A, v[7:0]);
		chk("ctrlA reset", 10'h000, {2'h0, v[7:0]});
		rd(ADDR_CTRL_B, v[7:0]);
		chk("ctrlB reset", 10'h000, {2'h0, v[7:0]});
		wr(ADDR_CTRL_A, 8'hF7);
		rd(ADDR_CTRL_A, v[7:0]);
		chk("ctrlA bits", 10'h0F0, {2'h0, v[7:0]});
		wr(ADDR_CTRL_A, 8'h00);
		wr(ADDR_CTRL_B, 8'h5A);
		rd(ADDR_CTRL_B, v[7:0]);
		chk("ctrlB", 10'h05A, {2'h0, v[7:0]});
		wr16(ADDR_CMPA_HI, 10'h2AB);
		wr16(ADDR_PER_HI, 10'h155);
		rd16(ADDR_CMPA_HI, v);
		chk("compareA", 10'h2AB, v);
		rd16(ADDR_PER_HI, v);
		chk("period", 10'h155, v);
		wr16(ADDR_CNT_HI, 10'h3C5);
		rd16(ADDR_CNT_HI, v);
		chk("counter load", 10'h000, v);
		// Compare output action for each pin function, level and polarity
		wr16(ADDR_CMPA_HI, 10'd40);
		for (int pol = 0; pol < 2; pol++) begin
			for (int oc = 0; oc < 2; oc++) begin
				for (int fn = 0; fn < 4; fn++) begin
					setup({2'b00, fn[1:0], oc[0], pol[0], 2'b01}, 8'h18);
					repeat (6) @(posedge sys_clk);
					chkPins(oc[0] ^ pol[0]);
					waitIrq(1'b0, n);
					repeat (3) @(posedge sys_clk);
					v[0] = (fn == 0) ? oc[0] : (fn == 1) ? 1'b0 : (fn == 2) ? 1'b1 : ~oc[0];
					chkPins(v[0] ^ pol[0]);
				end
			end
		end
		// Pause and stop keep the counter still
		wr(ADDR_CTRL_A, 8'h98);
		rd16(ADDR_CNT_HI, v);
		repeat (9) @(posedge sys_clk);
		rd16(ADDR_CNT_HI, w);
		chk("paused counter", v, w);
		wr(ADDR_CTRL_A, 8'h18);
		waitIrq(1'b0, n);
		waitIrq(1'b0, n);
		chk("resumed interval", 10'd41, n[9:0]);
		wr(ADDR_CTRL_A, 8'h10);
		rd16(ADDR_CNT_HI, v);
		repeat (9) @(posedge sys_clk);
		rd16(ADDR_CNT_HI, w);
		chk("stopped counter", v, w);
		// Every clock source; clear on compare A match, then on period match
		wr16(ADDR_CMPA_HI, 10'd3);
		wr16(ADDR_PER_HI, 10'd7);
		for (int s = 0; s < 8; s++) begin
			clkRun <= (s >= 6);
			setup(8'h01, {1'b0, s[2:0], 4'h8});
			waitIrq(1'b0, n);
			waitIrq(1'b0, n);
			waitIrq(1'b0, n);
			chk("tick interval", 10'(4 * divTab[s]), n[9:0]);
		end
		clkRun <= 1'b0;
		setup(8'h00, 8'h18);
		waitIrq(1'b1, n);
		waitIrq(1'b1, n);
		chk("period interval", 10'd8, n[9:0]);
		// PWM mode forced levels
		for (int oc = 0; oc < 2; oc++) begin
			for (int fn = 0; fn < 2; fn++) begin
				setup({2'b10, fn[1:0], oc[0], 3'b000}, 8'h18);
				repeat (6) @(posedge sys_clk);
				chkPins(fn[0] ? oc[0] : ~oc[0]);
			end
		end
		// PWM waveform, single pulse, timer/counter pins, overflow in capture mode
		setup(8'hA8, 8'h18);
		repeat (6) @(posedge sys_clk);
		cntOnes(16, 1'b1, n);
		chk("pwm active cycles", 10'd6, n[9:0]);
		setup(8'hB8, 8'h18);
		cntOnes(12, 1'b1, n);
		chk("single pulse cycles", 10'd4, n[9:0]);
		setup(8'hC4, 8'h18);
		repeat (6) @(posedge sys_clk);
		chkPins(1'b0);
		setup(8'h40, 8'h18);
		waitIrq(1'b1, n);
		waitIrq(1'b1, n);
		chk("overflow interval", 10'h001, {9'h0, n == (1 << CNT_W)});
		// Capture edges on the capture pin, counter held still
		for (int fn = 0; fn < 4; fn++) begin
			setup({2'b01, fn[1:0], 4'h0}, 8'h68);
			capLevel <= 1'b1;
			cntOnes(12, 1'b0, n);
			capLevel <= 1'b0;
			cntOnes(12, 1'b0, k);
			chk("capture rise", {9'h0, fn == 0 || fn == 2}, n[9:0]);
			chk("capture fall", {9'h0, fn == 1 || fn == 2}, k[9:0]);
		end
		endOfTest;
	end
endmodule
